// ---- verilog/tcl_pkg.sv ----
/*
 * package for the telegram control logic: register map, field positions,
 * reset values, channel plan and sequencer states.
 * assumes a 32-bit AHB-Lite bus with word-aligned registers.
 */
package tcl_pkg;
    // ****************************************
    // register map (byte addresses)
    // ****************************************
    localparam logic [7:0] TCL_OFS_CTRL = 8'h00;
    localparam logic [7:0] TCL_OFS_CMD = 8'h04;
    localparam logic [7:0] TCL_OFS_STATUS = 8'h08;
    localparam logic [7:0] TCL_OFS_CHAN = 8'h0c;
    localparam logic [7:0] TCL_OFS_FKEY0 = 8'h10;
    localparam logic [7:0] TCL_OFS_UKEY0 = 8'h20;
    localparam int TCL_KEY_WORDS = 4;
    // ****************************************
    // control fields
    // ****************************************
    localparam int TCL_CTRL_ZGP = 0;
    localparam int TCL_CTRL_RATE2M = 1;
    localparam int TCL_CTRL_KEYUSER = 2;
    localparam int TCL_CTRL_INVDIR = 3;
    localparam logic [3:0] TCL_CTRL_RST = 4'h0;
    // ****************************************
    // command fields (write-one pulses)
    // ****************************************
    localparam int TCL_CMD_COMM = 0;
    localparam int TCL_CMD_FRESET = 1;
    localparam int TCL_CMD_DECOMM = 2;
    // ****************************************
    // channel plan
    // ****************************************
    localparam logic [6:0] TCL_CH_ADV0 = 7'h25;
    localparam logic [6:0] TCL_CH_ADV1 = 7'h26;
    localparam logic [6:0] TCL_CH_ADV2 = 7'h27;
    localparam logic [6:0] TCL_CH_DATA_LO_MAX = 7'h0a;
    localparam logic [6:0] TCL_CH_DATA_HI_MAX = 7'h24;
    localparam logic [6:0] TCL_CH_CUST_MIN = 7'h28;
    localparam logic [6:0] TCL_CH_CUST_MAX = 7'h4e;
    localparam logic [11:0] TCL_F_ADV0 = 12'h962;
    localparam logic [11:0] TCL_F_ADV1 = 12'h97a;
    localparam logic [11:0] TCL_F_ADV2 = 12'h9b0;
    localparam logic [11:0] TCL_F_DATA_LO = 12'h964;
    localparam logic [11:0] TCL_F_DATA_HI_BASE = 12'h966;
    localparam logic [11:0] TCL_F_CUST_BASE = 12'h913;
    localparam int TCL_SLOTS = 3;
    localparam logic [1:0] TCL_SLOT_LAST = 2'h2;
    localparam logic [31:0] TCL_LFSR_SEED = 32'h0000_0001;
    typedef enum logic [3:0] {
        TCL_IDLE = 4'b0001,
        TCL_SAMPLE = 4'b0010,
        TCL_SEND = 4'b0100,
        TCL_WAIT = 4'b1000
    } tcl_state_t;
endpackage

// ---- verilog/tcl_top.sv ----
/*
 * telegram control logic: actuation detect, telegram type choice,
 * key/protocol/rate selection, channel-to-frequency sequencing, AHB-Lite
 * configuration slave (stands in for the contactless configuration side).
 * assumes a radio on the same clock that takes tx_req_o and answers
 * tx_done_i, and harvester polarity given as two digital levels.
 */
// Notes on behaviour
// [RULE1] contact input grounded means active, open means inactive.
// [RULE2] every data telegram carries both contact states.
// [RULE3] outside circuit only grounds or leaves contacts open, never drives high.
// [RULE4] ble telegrams after configuration reset; zgp only when selected.
// [RULE5] learn held or pending request makes the telegram a commissioning one.
// [RULE6] learn held: only the first recorded direction sends, the other sends nothing.
// [RULE7] pending request gives one commissioning telegram, then is cleared.
// [RULE8] learn released and nothing pending: every actuation sends a data telegram.
// [RULE9] data and commissioning share one outer format, payload differs.
// [RULE10] in zgp mode learn starts channel selection.
// [RULE11] factory key readable, writable, restored by factory reset.
// [RULE12] user key writable, always reads back as zero.
// [RULE13] factory reset, or zgp decommission, gives user key a random value.
// [RULE14] factory key used by default; user key when selected.
// [RULE15] 1 mbit/s by default; 2 mbit/s when selected.
// [RULE16] default channels 37, 38, 39; configurable.
// [RULE17] channel 37/38/39 map to 2402/2426/2480 mhz.
// [RULE18] data channels 0-10 from 2404, 11-36 from 2428, 2 mhz steps.
// [RULE19] custom channels 40-78 map to 2403-2479 mhz odd.
// [RULE20] pin b above pin a is a press; configurable inversion.
// [RULE21] contacts and learn sampled once per actuation, held for the sequence.
`timescale 1ns/1ps
module tcl_top
    import tcl_pkg::*;
#(
    parameter logic [127:0] FACTORY_KEY = 128'h0123_4567_89ab_cdef_fedc_ba98_7654_3210
) (
    input wire logic clk_i,
    input wire logic nrst_i,
    input wire logic hsel_i,
    input wire logic [31:0] haddr_i,
    input wire logic [1:0] htrans_i,
    input wire logic hwrite_i,
    input wire logic [2:0] hsize_i,
    input wire logic [31:0] hwdata_i,
    input wire logic hready_i,
    output logic [31:0] hrdata_o,
    output logic hreadyout_o,
    output logic hresp_o,
    input wire logic contact_in_a_n_i,
    input wire logic contact_in_b_n_i,
    input wire logic learn_button_n_i,
    input wire logic harvester_pin_a_i,
    input wire logic harvester_pin_b_i,
    input wire logic tx_done_i,
    output logic tx_req_o,
    output logic tx_commission_o,
    output logic tx_press_o,
    output logic tx_contact_a_o,
    output logic tx_contact_b_o,
    output logic tx_zgp_o,
    output logic tx_rate_2m_o,
    output logic [127:0] tx_key_o,
    output logic [6:0] tx_channel_o,
    output logic [11:0] tx_freq_mhz_o,
    output logic chsel_start_o
);
    // ****************************************
    // channel decode
    // ****************************************
    function automatic logic [11:0] chan_freq(input logic [6:0] ch);
        logic [11:0] c2;
        c2 = {4'h0, ch, 1'b0};
        if (ch == TCL_CH_ADV0) begin
            chan_freq = TCL_F_ADV0; // [RULE17]
        end else if (ch == TCL_CH_ADV1) begin
            chan_freq = TCL_F_ADV1; // [RULE17]
        end else if (ch == TCL_CH_ADV2) begin
            chan_freq = TCL_F_ADV2; // [RULE17]
        end else if (ch <= TCL_CH_DATA_LO_MAX) begin
            chan_freq = TCL_F_DATA_LO + c2; // [RULE18]
        end else if (ch <= TCL_CH_DATA_HI_MAX) begin
            chan_freq = TCL_F_DATA_HI_BASE + c2; // [RULE18]
        end else if (ch >= TCL_CH_CUST_MIN && ch <= TCL_CH_CUST_MAX) begin
            chan_freq = TCL_F_CUST_BASE + c2; // [RULE19]
        end else begin
            chan_freq = 12'h000;
        end
    endfunction

    // ****************************************
    // pin synchronisers
    // ****************************************
    logic [4:0] pin_raw;
    logic [4:0] sync1_r;
    logic [4:0] sync2_r;
    assign pin_raw = {harvester_pin_b_i, harvester_pin_a_i, learn_button_n_i,
                      contact_in_b_n_i, contact_in_a_n_i};
    always_ff @(posedge clk_i) begin
        if (!nrst_i) begin
            sync1_r <= 5'h07;
            sync2_r <= 5'h07;
        end else begin
            sync1_r <= pin_raw;
            sync2_r <= sync1_r;
        end
    end

    logic learn_held;
    logic act_level;
    logic act_prev_r;
    logic act_event;
    logic dir_press;
    logic [3:0] ctrl_r;
    assign learn_held = ~sync2_r[2];
    assign act_level = sync2_r[3] ^ sync2_r[4];
    assign act_event = act_level & ~act_prev_r;
    // polarity decides direction; inversion is a configuration option
    assign dir_press = (sync2_r[4] & ~sync2_r[3]) ^ ctrl_r[TCL_CTRL_INVDIR]; // [RULE20]
    always_ff @(posedge clk_i) begin
        if (!nrst_i) begin
            act_prev_r <= 1'b0;
        end else begin
            act_prev_r <= act_level;
        end
    end

    // ****************************************
    // AHB-Lite slave
    // ****************************************
    logic [7:0] waddr_r;
    logic wpend_r;
    logic rd_acc;
    logic wr_acc;
    logic [6:0] chan_r [TCL_SLOTS];
    logic [31:0] fkey_r [TCL_KEY_WORDS];
    logic [31:0] ukey_r [TCL_KEY_WORDS];
    logic [31:0] rd_nxt;
    logic [31:0] status_w;
    logic [31:0] lfsr_r;
    logic cmd_comm;
    logic cmd_freset;
    logic cmd_decomm;
    logic refresh_ukey;
    logic comm_pend_r;
    logic arm_r;
    logic arm_dir_r;
    logic busy;
    logic last_comm_r;
    tcl_state_t state_r;

    assign rd_acc = hsel_i & htrans_i[1] & hready_i & ~hwrite_i;
    assign wr_acc = hsel_i & htrans_i[1] & hready_i & hwrite_i;
    assign busy = (state_r != TCL_IDLE);
    assign status_w = {26'h0, sync2_r[1] == 1'b0, last_comm_r, busy, arm_dir_r, arm_r,
                       comm_pend_r};

    always_ff @(posedge clk_i) begin
        if (!nrst_i) begin
            waddr_r <= 8'h00;
            wpend_r <= 1'b0;
            hreadyout_o <= 1'b0;
            hresp_o <= 1'b0;
        end else begin
            wpend_r <= wr_acc;
            hreadyout_o <= 1'b1;
            hresp_o <= 1'b0;
            if (wr_acc) begin
                waddr_r <= {haddr_i[7:2], 2'b00};
            end
        end
    end

    always_comb begin
        rd_nxt = 32'h0;
        case ({haddr_i[7:2], 2'b00})
            TCL_OFS_CTRL: rd_nxt = {28'h0, ctrl_r};
            TCL_OFS_STATUS: rd_nxt = status_w;
            TCL_OFS_CHAN: rd_nxt = {9'h0, chan_r[2], 1'b0, chan_r[1], 1'b0, chan_r[0]};
            default: begin
                // user key words fall here and read zero
                if (haddr_i[7:4] == TCL_OFS_FKEY0[7:4]) begin
                    rd_nxt = fkey_r[haddr_i[3:2]]; // [RULE11]
                end
            end
        endcase
    end

    always_ff @(posedge clk_i) begin
        if (!nrst_i) begin
            hrdata_o <= 32'h0;
        end else if (rd_acc) begin
            hrdata_o <= rd_nxt; // [RULE12]
        end
    end

    assign cmd_comm = wpend_r & (waddr_r == TCL_OFS_CMD) & hwdata_i[TCL_CMD_COMM];
    assign cmd_freset = wpend_r & (waddr_r == TCL_OFS_CMD) & hwdata_i[TCL_CMD_FRESET];
    assign cmd_decomm = wpend_r & (waddr_r == TCL_OFS_CMD) & hwdata_i[TCL_CMD_DECOMM];
    // decommission refreshes the user key only in zgp operation
    assign refresh_ukey = cmd_freset | (cmd_decomm & ctrl_r[TCL_CTRL_ZGP]); // [RULE13]

    always_ff @(posedge clk_i) begin
        if (!nrst_i) begin
            ctrl_r <= TCL_CTRL_RST; // [RULE4] [RULE14] [RULE15]
            chan_r[0] <= TCL_CH_ADV0; // [RULE16]
            chan_r[1] <= TCL_CH_ADV1;
            chan_r[2] <= TCL_CH_ADV2;
        end else if (cmd_freset) begin
            ctrl_r <= TCL_CTRL_RST;
            chan_r[0] <= TCL_CH_ADV0;
            chan_r[1] <= TCL_CH_ADV1;
            chan_r[2] <= TCL_CH_ADV2;
        end else if (wpend_r && waddr_r == TCL_OFS_CTRL) begin
            ctrl_r <= hwdata_i[3:0];
        end else if (wpend_r && waddr_r == TCL_OFS_CHAN) begin
            chan_r[0] <= hwdata_i[6:0]; // [RULE16]
            chan_r[1] <= hwdata_i[14:8];
            chan_r[2] <= hwdata_i[22:16];
        end
    end

    // free-running lfsr; sampled at an unpredictable moment for fresh keys
    always_ff @(posedge clk_i) begin
        if (!nrst_i) begin
            lfsr_r <= TCL_LFSR_SEED;
        end else begin
            lfsr_r <= {lfsr_r[30:0], lfsr_r[31] ^ lfsr_r[21] ^ lfsr_r[1] ^ lfsr_r[0]};
        end
    end

    genvar gk;
    generate
        for (gk = 0; gk < TCL_KEY_WORDS; gk++) begin : g_key
            always_ff @(posedge clk_i) begin
                if (!nrst_i) begin
                    fkey_r[gk] <= FACTORY_KEY[gk*32 +: 32];
                    ukey_r[gk] <= 32'h0;
                end else begin
                    if (cmd_freset) begin
                        fkey_r[gk] <= FACTORY_KEY[gk*32 +: 32]; // [RULE11]
                    end else if (wpend_r && waddr_r == TCL_OFS_FKEY0 + 8'(gk*4)) begin
                        fkey_r[gk] <= hwdata_i; // [RULE11]
                    end
                    if (refresh_ukey) begin
                        ukey_r[gk] <= lfsr_r ^ {lfsr_r[gk*8 +: 8], lfsr_r[31:8]}; // [RULE13]
                    end else if (wpend_r && waddr_r == TCL_OFS_UKEY0 + 8'(gk*4)) begin
                        ukey_r[gk] <= hwdata_i; // [RULE12]
                    end
                end
            end
        end
    endgenerate

    // ****************************************
    // telegram decision and sequencing
    // ****************************************
    logic samp_learn_r;
    logic samp_dir_r;
    logic is_comm;
    logic suppress;
    logic [1:0] slot_r;
    logic use_pend;
    logic ch_start;

    // pending request wins over the direction filter
    assign use_pend = comm_pend_r;
    assign suppress = ~use_pend & samp_learn_r & arm_r & (samp_dir_r != arm_dir_r); // [RULE6]
    assign is_comm = use_pend | samp_learn_r; // [RULE5] [RULE8]
    assign ch_start = (state_r == TCL_SAMPLE) & samp_learn_r & ~arm_r & ctrl_r[TCL_CTRL_ZGP];

    always_ff @(posedge clk_i) begin
        if (!nrst_i) begin
            samp_learn_r <= 1'b0;
            samp_dir_r <= 1'b0;
        end else if (state_r == TCL_IDLE && act_event) begin
            samp_learn_r <= learn_held; // [RULE21]
            samp_dir_r <= dir_press;
        end
    end

    // new request set wins over the clear when both fall in one cycle
    always_ff @(posedge clk_i) begin
        if (!nrst_i) begin
            comm_pend_r <= 1'b0;
        end else if (cmd_comm) begin
            comm_pend_r <= 1'b1;
        end else if (state_r == TCL_SAMPLE && use_pend) begin
            comm_pend_r <= 1'b0; // [RULE7]
        end
    end

    always_ff @(posedge clk_i) begin
        if (!nrst_i) begin
            arm_r <= 1'b0;
            arm_dir_r <= 1'b0;
        end else if (!learn_held && state_r == TCL_IDLE) begin
            arm_r <= 1'b0;
        end else if (state_r == TCL_SAMPLE && samp_learn_r && !arm_r) begin
            arm_r <= 1'b1; // [RULE6]
            arm_dir_r <= samp_dir_r;
        end
    end

    always_ff @(posedge clk_i) begin
        if (!nrst_i) begin
            chsel_start_o <= 1'b0;
        end else begin
            chsel_start_o <= ch_start; // [RULE10]
        end
    end

    always_ff @(posedge clk_i) begin
        if (!nrst_i) begin
            state_r <= TCL_IDLE;
            slot_r <= 2'h0;
        end else begin
            case (state_r)
                TCL_IDLE: begin
                    if (act_event) begin
                        state_r <= TCL_SAMPLE;
                    end
                end
                TCL_SAMPLE: begin
                    slot_r <= 2'h0;
                    state_r <= suppress ? TCL_IDLE : TCL_SEND;
                end
                TCL_SEND: begin
                    state_r <= TCL_WAIT;
                end
                TCL_WAIT: begin
                    if (tx_done_i) begin
                        if (slot_r == TCL_SLOT_LAST) begin
                            state_r <= TCL_IDLE;
                        end else begin
                            slot_r <= slot_r + 2'h1;
                            state_r <= TCL_SEND;
                        end
                    end
                end
                default: begin
                    state_r <= TCL_IDLE;
                end
            endcase
        end
    end

    // telegram attributes frozen at the decision, stable for all slots
    always_ff @(posedge clk_i) begin
        if (!nrst_i) begin
            tx_commission_o <= 1'b0;
            tx_press_o <= 1'b0;
            tx_contact_a_o <= 1'b0;
            tx_contact_b_o <= 1'b0;
            tx_zgp_o <= 1'b0;
            tx_rate_2m_o <= 1'b0;
            tx_key_o <= 128'h0;
            last_comm_r <= 1'b0;
        end else if (state_r == TCL_SAMPLE && !suppress) begin
            // one outer format; only the type flag changes the payload
            tx_commission_o <= is_comm; // [RULE9]
            last_comm_r <= is_comm;
            tx_press_o <= samp_dir_r;
            tx_contact_a_o <= ~sync2_r[0]; // [RULE1] [RULE2] [RULE21]
            tx_contact_b_o <= ~sync2_r[1]; // [RULE1] [RULE2] [RULE21]
            tx_zgp_o <= ctrl_r[TCL_CTRL_ZGP]; // [RULE4]
            tx_rate_2m_o <= ctrl_r[TCL_CTRL_RATE2M]; // [RULE15]
            tx_key_o <= ctrl_r[TCL_CTRL_KEYUSER] ? // [RULE14]
                {ukey_r[3], ukey_r[2], ukey_r[1], ukey_r[0]} :
                {fkey_r[3], fkey_r[2], fkey_r[1], fkey_r[0]};
        end
    end

    always_ff @(posedge clk_i) begin
        if (!nrst_i) begin
            tx_req_o <= 1'b0;
            tx_channel_o <= 7'h0;
            tx_freq_mhz_o <= 12'h0;
        end else begin
            if (state_r == TCL_SEND) begin
                tx_req_o <= 1'b1;
                tx_channel_o <= chan_r[slot_r];
                tx_freq_mhz_o <= chan_freq(chan_r[slot_r]); // [RULE17] [RULE18] [RULE19]
            end else if (tx_done_i) begin
                tx_req_o <= 1'b0;
            end
        end
    end
endmodule

// ---- testbench/tcl_chk.sv ----
/* port checker for tcl_top: channel plan, slot handshake, telegram hold.
   assumes a bind onto tcl_top, one clock, synchronous active-low reset. */
`timescale 1ns/1ps
module tcl_chk (
    input wire logic clk_i,
    input wire logic nrst_i,
    input wire logic contact_in_a_n_i,
    input wire logic tx_done_i,
    input wire logic tx_req_o,
    input wire logic tx_commission_o,
    input wire logic tx_press_o,
    input wire logic tx_contact_a_o,
    input wire logic tx_contact_b_o,
    input wire logic [127:0] tx_key_o,
    input wire logic [6:0] tx_channel_o,
    input wire logic [11:0] tx_freq_mhz_o,
    input wire logic chsel_start_o
);
    default clocking @(posedge clk_i); endclocking
    default disable iff (!nrst_i);
    property p_adv;
        tx_req_o && tx_channel_o inside {[7'h25:7'h27]} |-> tx_freq_mhz_o ==
            (tx_channel_o == 7'h25 ? 12'h962 : (tx_channel_o == 7'h26 ? 12'h97a : 12'h9b0));
    endproperty
    a_adv: assert property (p_adv) else $error("advertising frequency wrong");
    property p_dlo;
        tx_req_o && tx_channel_o <= 7'h0a
            |-> tx_freq_mhz_o == 12'h964 + {4'h0, tx_channel_o, 1'b0};
    endproperty
    a_dlo: assert property (p_dlo) else $error("low data frequency wrong");
    property p_dhi;
        tx_req_o && tx_channel_o inside {[7'h0b:7'h24]}
            |-> tx_freq_mhz_o == 12'h97c + {4'h0, tx_channel_o - 7'h0b, 1'b0};
    endproperty
    a_dhi: assert property (p_dhi) else $error("high data frequency wrong");
    property p_cust;
        tx_req_o && tx_channel_o inside {[7'h28:7'h4e]}
            |-> tx_freq_mhz_o == 12'h963 + {4'h0, tx_channel_o - 7'h28, 1'b0};
    endproperty
    a_cust: assert property (p_cust) else $error("custom frequency wrong");
    // telegram attributes may not move while a slot is on air
    property p_hold;
        tx_req_o && $past(tx_req_o) |-> $stable({tx_commission_o, tx_press_o,
            tx_contact_a_o, tx_contact_b_o, tx_key_o});
    endproperty
    a_hold: assert property (p_hold) else $error("telegram changed mid slot");
    property p_done;
        tx_req_o && tx_done_i |=> !tx_req_o;
    endproperty
    a_done: assert property (p_done) else $error("request not dropped after done");
    property p_cont;
        $rose(tx_req_o) |-> tx_contact_a_o == !$past(contact_in_a_n_i, 4);
    endproperty
    a_cont: assert property (p_cont) else $error("contact polarity wrong");
    property p_chsel;
        chsel_start_o |=> !chsel_start_o;
    endproperty
    a_chsel: assert property (p_chsel) else $error("channel select not a pulse");
    c_comm: cover property (tx_req_o && tx_commission_o);
    c_chsel: cover property (chsel_start_o);
    c_cust: cover property (tx_req_o && tx_channel_o == 7'h4e);
endmodule

// ---- testbench/tcl_radio_model.sv ----
/* radio receiver stand-in: acknowledges each transmit slot after a set
   delay and logs the channel. assumes the tcl_top request/done handshake. */
`timescale 1ns/1ps
module tcl_radio_model (
    input wire logic clk_i,
    input wire logic nrst_i,
    input wire logic tx_req_i,
    input wire logic [6:0] tx_channel_i,
    input wire logic [3:0] delay_i,
    output logic tx_done_o,
    output logic [7:0] slots_o
);
    logic [3:0] wait_r;
    logic [6:0] ch_log [0:7];
    // done is one cycle and never raised without a live request
    always_ff @(posedge clk_i) begin
        if (!nrst_i) begin
            wait_r <= 4'h0;
            slots_o <= 8'h0;
            tx_done_o <= 1'b0;
        end else begin
            tx_done_o <= 1'b0;
            if (tx_req_i && !tx_done_o) begin
                wait_r <= wait_r + 4'h1;
                if (wait_r == delay_i) begin
                    wait_r <= 4'h0;
                    tx_done_o <= 1'b1;
                    slots_o <= slots_o + 8'h1;
                    ch_log[slots_o[2:0]] <= tx_channel_i;
                end
            end
        end
    end
endmodule

// ---- testbench/test_telegram_control_logic.sv ----
/* self-checking bench for tcl_top: ahb-lite master, radio model, scenarios.
   assumes tcl_pkg, tcl_top, tcl_radio_model and tcl_chk compiled first. */
`timescale 1ns/1ps
module test_telegram_control_logic
    import tcl_pkg::*;
;
    // arbitrary key values
    localparam logic [127:0] FKEY = 128'h0f1e_2d3c_4b5a_6978_8796_a5b4_c3d2_e1f0;
    localparam logic [127:0] UKEY = 128'h1111_2222_3333_4444_5555_6666_7777_8888;
    logic clk_i = 1'b0, nrst_i = 1'b0, hsel = 1'b0, hwrite = 1'b0, chsel_seen = 1'b0;
    logic cont_a_n = 1'b1, cont_b_n = 1'b1, learn_n = 1'b1, pin_a = 1'b0, pin_b = 1'b0;
    logic [31:0] haddr = 32'h0, hwdata = 32'h0;
    logic [1:0] htrans = 2'h0;
    logic [3:0] dly = 4'h0;
    logic [31:0] hrdata, rd;
    logic hready, hresp, done, req, comm, press, ca, cb, zgp, rate2m, chsel;
    logic [127:0] key, prev;
    logic [6:0] ch;
    logic [7:0] slots;
    int mismatches = 0;
    int check_count = 0;
    always #4 clk_i = ~clk_i;
    tcl_top #(.FACTORY_KEY(FKEY)) dut_u (
        .clk_i(clk_i), .nrst_i(nrst_i), .hsel_i(hsel), .haddr_i(haddr), .htrans_i(htrans),
        .hwrite_i(hwrite), .hsize_i(3'h2), .hwdata_i(hwdata), .hready_i(hready),
        .hrdata_o(hrdata), .hreadyout_o(hready), .hresp_o(hresp),
        .contact_in_a_n_i(cont_a_n), .contact_in_b_n_i(cont_b_n), .learn_button_n_i(learn_n),
        .harvester_pin_a_i(pin_a), .harvester_pin_b_i(pin_b), .tx_done_i(done),
        .tx_req_o(req), .tx_commission_o(comm), .tx_press_o(press), .tx_contact_a_o(ca),
        .tx_contact_b_o(cb), .tx_zgp_o(zgp), .tx_rate_2m_o(rate2m), .tx_key_o(key),
        .tx_channel_o(ch), .tx_freq_mhz_o(), .chsel_start_o(chsel));
    tcl_radio_model radio_u (.clk_i(clk_i), .nrst_i(nrst_i), .tx_req_i(req),
        .tx_channel_i(ch), .delay_i(dly), .tx_done_o(done), .slots_o(slots));
    task chk(input string what, input logic [127:0] exp, input logic [127:0] got);
        check_count++;
        if (got !== exp) begin
            mismatches++;
            $display("[FAIL] %s expected %h seen %h", what, exp, got);
        end
    endtask
    task bus(input logic wr, input logic [7:0] a, input logic [31:0] d);
        hsel <= 1'b1;
        haddr <= {24'h0, a};
        htrans <= 2'h2;
        hwrite <= wr;
        do @(posedge clk_i); while (hready !== 1'b1);
        htrans <= 2'h0;
        hwdata <= d;
        do @(posedge clk_i); while (hready !== 1'b1);
        rd = hrdata;
    endtask
    // pins go back to equal after each sequence, so every call is a fresh edge
    task act(input logic dir, input logic sends);
        int n;
        logic [7:0] s0;
        repeat (8) @(posedge clk_i);
        s0 = slots;
        n = 0;
        pin_a <= !dir;
        pin_b <= dir;
        while (slots !== s0 + 8'h3 && n < 200) begin
            @(posedge clk_i);
            // channel select is a one-cycle pulse, caught here at every edge
            if (chsel === 1'b1) chsel_seen = 1'b1;
            n++;
        end
        chk("slot count", sends ? s0 + 8'h3 : s0, slots);
        pin_a <= 1'b0;
        pin_b <= 1'b0;
    endtask
    task tel(input logic cm, input logic pr, input logic [127:0] k);
        chk("commission", cm, comm);
        chk("press", pr, press);
        chk("key", k, key);
    endtask
    task chans(input logic [20:0] cs);
        logic [2:0] j;
        j = slots[2:0] - 3'h3;
        chk("channels", cs, {radio_u.ch_log[j + 3'h2], radio_u.ch_log[j + 3'h1],
            radio_u.ch_log[j]});
    endtask
    task s_reset;
        chk("hresp", 1'b0, hresp);
        bus(1'b0, TCL_OFS_CTRL, 32'h0);
        chk("ctrl", 32'h0, rd);
        bus(1'b0, TCL_OFS_CHAN, 32'h0);
        chk("chan", 32'h0027_2625, rd);
        bus(1'b0, TCL_OFS_FKEY0 + 8'h4, 32'h0);
        chk("fkey word", FKEY[63:32], rd);
        for (int i = 0; i < 4; i++) begin
            bus(1'b1, TCL_OFS_UKEY0 + 8'(4 * i), UKEY[32 * i +: 32]);
            bus(1'b0, TCL_OFS_UKEY0 + 8'(4 * i), 32'h0);
            chk("ukey read", 32'h0, rd);
        end
        bus(1'b0, 8'h40, 32'h0);
        chk("unmapped", 32'h0, rd);
    endtask
    task s_data;
        cont_a_n <= 1'b0;
        act(1'b1, 1'b1);
        tel(1'b0, 1'b1, FKEY);
        chk("contacts", 2'b10, {ca, cb});
        chk("zgp rate", 2'b00, {zgp, rate2m});
        chans({7'h27, 7'h26, 7'h25});
        cont_a_n <= 1'b1;
        cont_b_n <= 1'b0;
        act(1'b0, 1'b1);
        tel(1'b0, 1'b0, FKEY);
        chk("contacts", 2'b01, {ca, cb});
    endtask
    task s_cfg;
        bus(1'b1, TCL_OFS_CTRL, 32'hf);
        bus(1'b1, TCL_OFS_CHAN, 32'h000b_0a00);
        dly <= 4'h9;
        act(1'b1, 1'b1);
        tel(1'b0, 1'b0, UKEY);
        chk("zgp rate", 2'b11, {zgp, rate2m});
        chans({7'h0b, 7'h0a, 7'h00});
        bus(1'b1, TCL_OFS_CHAN, 32'h004e_2824);
        act(1'b0, 1'b1);
        chans({7'h4e, 7'h28, 7'h24});
        bus(1'b1, TCL_OFS_CTRL, 32'h0);
        dly <= 4'h0;
    endtask
    task s_nfc;
        bus(1'b1, TCL_OFS_CMD, 32'h1);
        bus(1'b0, TCL_OFS_STATUS, 32'h0);
        chk("status", 32'h21, rd);
        act(1'b0, 1'b1);
        tel(1'b1, 1'b0, FKEY);
        bus(1'b0, TCL_OFS_STATUS, 32'h0);
        chk("status", 32'h30, rd);
        act(1'b1, 1'b1);
        tel(1'b0, 1'b1, FKEY);
    endtask
    task s_learn;
        bus(1'b1, TCL_OFS_CTRL, 32'h1);
        learn_n <= 1'b0;
        chsel_seen = 1'b0;
        act(1'b1, 1'b1);
        tel(1'b1, 1'b1, FKEY);
        chk("chsel", 1'b1, chsel_seen);
        act(1'b0, 1'b0);
        act(1'b1, 1'b1);
        chk("commission", 1'b1, comm);
        learn_n <= 1'b1;
        act(1'b0, 1'b1);
        tel(1'b0, 1'b0, FKEY);
    endtask
    task s_keys;
        bus(1'b1, TCL_OFS_FKEY0, 32'h1234_5678);
        bus(1'b0, TCL_OFS_FKEY0, 32'h0);
        chk("fkey write", 32'h1234_5678, rd);
        bus(1'b1, TCL_OFS_CTRL, 32'h5);
        bus(1'b1, TCL_OFS_CMD, 32'h4);
        act(1'b1, 1'b1);
        chk("key renewed", 1'b1, key !== UKEY);
        prev = key;
        bus(1'b1, TCL_OFS_CMD, 32'h2);
        bus(1'b0, TCL_OFS_FKEY0, 32'h0);
        chk("fkey restored", FKEY[31:0], rd);
        bus(1'b0, TCL_OFS_CTRL, 32'h0);
        chk("ctrl restored", 32'h0, rd);
        bus(1'b1, TCL_OFS_CTRL, 32'h4);
        act(1'b1, 1'b1);
        chk("key renewed", 1'b1, key !== prev);
    endtask
    task test_done;
        if (mismatches == 0 && check_count > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask
    initial begin
        repeat (5) @(posedge clk_i);
        nrst_i <= 1'b1;
        repeat (2) @(posedge clk_i);
        s_reset;
        s_data;
        s_cfg;
        s_nfc;
        s_learn;
        s_keys;
        test_done;
    end
    initial begin
        repeat (20000) @(posedge clk_i);
        mismatches++;
        test_done;
    end
endmodule
bind tcl_top tcl_chk chk_u (.clk_i(clk_i), .nrst_i(nrst_i),
    .contact_in_a_n_i(contact_in_a_n_i), .tx_done_i(tx_done_i), .tx_req_o(tx_req_o),
    .tx_commission_o(tx_commission_o), .tx_press_o(tx_press_o),
    .tx_contact_a_o(tx_contact_a_o), .tx_contact_b_o(tx_contact_b_o), .tx_key_o(tx_key_o),
    .tx_channel_o(tx_channel_o), .tx_freq_mhz_o(tx_freq_mhz_o), .chsel_start_o(chsel_start_o));
